// *** rtl/hvwf_pkg.sv ***
// Constants and types for the HDTV video word formatter
package hvwf_pkg;
  // Line formats
  typedef enum logic [1:0] {
    FMT_1125 = 2'b00,
    FMT_1250_FAST = 2'b01,
    FMT_1250_SLOW = 2'b10
  } hvwf_fmt_e;
  // Position of the sample counter within the digital line
  typedef enum logic [1:0] {
    REG_END_CODE = 2'b00,
    REG_BLANK = 2'b01,
    REG_START_CODE = 2'b10,
    REG_ACTIVE = 2'b11
  } hvwf_region_e;
  // Line lengths, line start before sync edge, active start after sync edge (clocks)
  localparam logic [11:0] LINE_LEN_1125 = 12'h898;
  localparam logic [11:0] PRE_SYNC_1125 = 12'h058;
  localparam logic [11:0] ACT_SYNC_1125 = 12'h0c0;
  localparam logic [11:0] LINE_LEN_1250F = 12'h900;
  localparam logic [11:0] PRE_SYNC_1250F = 12'h080;
  localparam logic [11:0] ACT_SYNC_1250F = 12'h100;
  localparam logic [11:0] LINE_LEN_1250S = 12'h6c0;
  localparam logic [11:0] PRE_SYNC_1250S = 12'h060;
  localparam logic [11:0] ACT_SYNC_1250S = 12'h0c0;
  // Timing code length and sync edge detection latency (clocks)
  localparam logic [11:0] CODE_LEN = 12'h004;
  localparam logic [11:0] SYNC_LAT = 12'h003;
  // Code and video levels on the 10-bit scale
  localparam logic [9:0] CODE_ONES = 10'h3ff;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_8BIT_MASK = 10'h3fc;
  localparam logic [9:0] VID_MIN = 10'h004;
  localparam logic [9:0] VID_MAX = 10'h3fb;
  localparam logic [9:0] LVL_BLACK = 10'h040;
  localparam logic [9:0] LVL_ACHROM = 10'h200;
  // Lane positions inside the 30-bit link word
  localparam int LANE0_LSB = 0;
  localparam int LANE1_LSB = 10;
  localparam int LANE2_LSB = 20;
  localparam int LANE_W = 10;
  localparam int WORD_W = 30;
  localparam int FIFO_DEPTH = 16;
endpackage : hvwf_pkg

// *** rtl/hvwf_formatter.sv ***
// HDTV video word formatter: line timing, timing codes, sample multiplex and input FIFO
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module hvwf_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("hvwf_fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_ff, rdPtr_ff, nxt_wrPtr, nxt_rdPtr;
  logic ready_ff, empty_ff, nxt_full, nxt_empty;
  logic doWrite, doRead;

  always_comb begin
    doWrite = inValid & ready_ff;
    doRead = outReady & ~empty_ff;
    nxt_wrPtr = doWrite ? wrPtr_ff + 1'b1 : wrPtr_ff;
    nxt_rdPtr = doRead ? rdPtr_ff + 1'b1 : rdPtr_ff;
    nxt_empty = nxt_wrPtr == nxt_rdPtr;
    nxt_full = (nxt_wrPtr[AW] != nxt_rdPtr[AW]) && (nxt_wrPtr[AW-1:0] == nxt_rdPtr[AW-1:0]);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      ready_ff <= 1'b1;
      empty_ff <= 1'b1;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      ready_ff <= ~nxt_full;
      empty_ff <= nxt_empty;
    end
  end

  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  assign inReady = ready_ff;
  assign outValid = ~empty_ff;
  assign outData = mem[rdPtr_ff[AW-1:0]];
endmodule : hvwf_fifo

////////////////////////////////////////////////////////////////////////////////
module hvwf_formatter #(
  parameter int FIFO_DEPTH = hvwf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Configuration straps and sync reference (asynchronous pins)
  input wire logic [1:0] lineFormat,
  input wire logic rgbMode,
  input wire logic tenBit,
  input wire logic analogSyncRefEdge,
  // Field state from upstream timing logic
  input wire logic fieldSecond,
  input wire logic vertBlank,
  // Sample stream in: {red_diff_sample, blue_diff_sample, Y} or {R, B, G}
  input wire logic vidValid,
  input wire logic [hvwf_pkg::WORD_W-1:0] vidData,
  output logic vidReady,
  // Link out (one-way to a single destination)
  output logic [hvwf_pkg::WORD_W-1:0] linkWord_ff,
  output logic underrun_ff,
  output logic locked_ff
);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("hvwf_formatter needs a FIFO depth of at least 2");
  end

  function automatic logic [9:0] clampVid(input logic [9:0] v, input logic full);
    logic [9:0] c;
    c = (v < hvwf_pkg::VID_MIN) ? hvwf_pkg::VID_MIN : ((v > hvwf_pkg::VID_MAX) ? hvwf_pkg::VID_MAX : v);
    clampVid = full ? c : (c & hvwf_pkg::CODE_8BIT_MASK);
  endfunction : clampVid

  //////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for pins
  logic [4:0] pinMeta_ff, pinSync_ff;
  logic syncPrev_ff;
  logic syncEdge;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
      syncPrev_ff <= 1'b0;
    end else begin
      pinMeta_ff <= {analogSyncRefEdge, tenBit, rgbMode, lineFormat};
      pinSync_ff <= pinMeta_ff;
      syncPrev_ff <= pinSync_ff[4];
    end
  end
  assign syncEdge = pinSync_ff[4] & ~syncPrev_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Input FIFO; the drain stalls outside active video, so the source is held off
  logic fifoValid, fifoPop, fifoReady;
  logic [hvwf_pkg::WORD_W-1:0] fifoData;
  hvwf_fifo #(.WIDTH(hvwf_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .inValid(vidValid),
    .inData(vidData),
    .inReady(fifoReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(fifoPop)
  );
  assign vidReady = fifoReady;

  //////////////////////////////////////////////////////////////////////////////
  // Line timing and word generation
  hvwf_pkg::hvwf_fmt_e fmt_ff, nxt_fmt;
  hvwf_pkg::hvwf_region_e region;
  logic [11:0] count_ff, nxt_count;
  logic rgb_ff, nxt_rgb, ten_ff, nxt_ten, fld_ff, nxt_fld, vbl_ff, nxt_vbl;
  logic [9:0] heldRed_ff, nxt_heldRed;
  logic [hvwf_pkg::WORD_W-1:0] nxt_linkWord;
  logic nxt_underrun, nxt_locked;
  logic [11:0] lineLen, preSync, actSync, activeStart, lineLast, expectCount;
  logic [9:0] codeLane, fourth, y0, c1;
  logic codeFull, wasCode_ff;

  always_comb begin
    case (fmt_ff)
      hvwf_pkg::FMT_1250_FAST: begin
        lineLen = hvwf_pkg::LINE_LEN_1250F;
        preSync = hvwf_pkg::PRE_SYNC_1250F;
        actSync = hvwf_pkg::ACT_SYNC_1250F;
      end
      hvwf_pkg::FMT_1250_SLOW: begin
        lineLen = hvwf_pkg::LINE_LEN_1250S;
        preSync = hvwf_pkg::PRE_SYNC_1250S;
        actSync = hvwf_pkg::ACT_SYNC_1250S;
      end
      default: begin
        lineLen = hvwf_pkg::LINE_LEN_1125;
        preSync = hvwf_pkg::PRE_SYNC_1125;
        actSync = hvwf_pkg::ACT_SYNC_1125;
      end
    endcase
    activeStart = preSync + actSync;
    lineLast = lineLen - 12'h001;
    expectCount = preSync + hvwf_pkg::SYNC_LAT;
    if (count_ff < hvwf_pkg::CODE_LEN) begin
      region = hvwf_pkg::REG_END_CODE;
    end else if (count_ff >= activeStart) begin
      region = hvwf_pkg::REG_ACTIVE;
    end else if (count_ff >= activeStart - hvwf_pkg::CODE_LEN) begin
      region = hvwf_pkg::REG_START_CODE;
    end else begin
      region = hvwf_pkg::REG_BLANK;
    end
    // Counter wraps at the line length and snaps to the sync edge
    nxt_locked = locked_ff;
    if (syncEdge) begin
      nxt_count = expectCount + 12'h001;
      nxt_locked = count_ff == expectCount;
    end else if (count_ff >= lineLast) begin
      nxt_count = '0;
    end else begin
      nxt_count = count_ff + 12'h001;
    end
    // Format and field flags only change where the line begins
    nxt_fmt = fmt_ff;
    nxt_rgb = rgb_ff;
    nxt_ten = ten_ff;
    nxt_fld = fld_ff;
    nxt_vbl = vbl_ff;
    if (count_ff == lineLast) begin
      nxt_fmt = (pinSync_ff[1:0] == 2'b11) ? hvwf_pkg::FMT_1125 : hvwf_pkg::hvwf_fmt_e'(pinSync_ff[1:0]);
      nxt_rgb = pinSync_ff[2] & (nxt_fmt == hvwf_pkg::FMT_1125);
      nxt_ten = pinSync_ff[3];
      nxt_fld = fieldSecond;
      nxt_vbl = vertBlank;
    end
    // Fourth code word with protection bits
    fourth = {1'b1, fld_ff, vbl_ff, region == hvwf_pkg::REG_END_CODE, vbl_ff ^ (region == hvwf_pkg::REG_END_CODE),
      fld_ff ^ (region == hvwf_pkg::REG_END_CODE), fld_ff ^ vbl_ff,
      fld_ff ^ vbl_ff ^ (region == hvwf_pkg::REG_END_CODE), 2'b00};
    case (count_ff[1:0])
      2'b00: codeLane = hvwf_pkg::CODE_ONES;
      2'b11: codeLane = fourth;
      default: codeLane = hvwf_pkg::CODE_ZERO;
    endcase
    codeFull = ten_ff | (fmt_ff != hvwf_pkg::FMT_1125);
    if (!codeFull) begin
      codeLane = codeLane & hvwf_pkg::CODE_8BIT_MASK;
    end
    y0 = clampVid(fifoData[hvwf_pkg::LANE0_LSB +: hvwf_pkg::LANE_W], ten_ff);
    c1 = clampVid(fifoData[hvwf_pkg::LANE1_LSB +: hvwf_pkg::LANE_W], ten_ff);
    fifoPop = 1'b0;
    nxt_underrun = 1'b0;
    nxt_heldRed = heldRed_ff;
    case (region)
      hvwf_pkg::REG_END_CODE, hvwf_pkg::REG_START_CODE: begin
        nxt_linkWord = {codeLane, codeLane, codeLane};
      end
      hvwf_pkg::REG_ACTIVE: begin
        fifoPop = fifoValid;
        nxt_underrun = ~fifoValid;
        if (!fifoValid) begin
          nxt_linkWord = {hvwf_pkg::LVL_BLACK, rgb_ff ? hvwf_pkg::LVL_BLACK : hvwf_pkg::LVL_ACHROM,
            hvwf_pkg::LVL_BLACK};
        end else if (rgb_ff) begin
          nxt_linkWord = {clampVid(fifoData[hvwf_pkg::LANE2_LSB +: hvwf_pkg::LANE_W], ten_ff), c1, y0};
        end else if (count_ff[0] == activeStart[0]) begin
          nxt_heldRed = clampVid(fifoData[hvwf_pkg::LANE2_LSB +: hvwf_pkg::LANE_W], ten_ff);
          nxt_linkWord = {hvwf_pkg::LVL_BLACK, c1, y0};
        end else begin
          nxt_linkWord = {hvwf_pkg::LVL_BLACK, heldRed_ff, y0};
        end
      end
      default: begin
        nxt_linkWord = {hvwf_pkg::LVL_BLACK, rgb_ff ? hvwf_pkg::LVL_BLACK : hvwf_pkg::LVL_ACHROM,
          hvwf_pkg::LVL_BLACK};
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fmt_ff <= hvwf_pkg::FMT_1125;
      count_ff <= '0;
      rgb_ff <= 1'b0;
      ten_ff <= 1'b1;
      fld_ff <= 1'b0;
      vbl_ff <= 1'b1;
      heldRed_ff <= hvwf_pkg::LVL_ACHROM;
      linkWord_ff <= {hvwf_pkg::LVL_BLACK, hvwf_pkg::LVL_ACHROM, hvwf_pkg::LVL_BLACK};
      underrun_ff <= 1'b0;
      locked_ff <= 1'b0;
      wasCode_ff <= 1'b0;
    end else begin
      fmt_ff <= nxt_fmt;
      count_ff <= nxt_count;
      rgb_ff <= nxt_rgb;
      ten_ff <= nxt_ten;
      fld_ff <= nxt_fld;
      vbl_ff <= nxt_vbl;
      heldRed_ff <= nxt_heldRed;
      linkWord_ff <= nxt_linkWord;
      underrun_ff <= nxt_underrun;
      locked_ff <= nxt_locked;
      wasCode_ff <= (region == hvwf_pkg::REG_END_CODE) || (region == hvwf_pkg::REG_START_CODE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_wrap;
    @(posedge clk) disable iff (!arst_n) (count_ff == lineLast && !syncEdge) |=> count_ff == 12'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("line counter did not wrap");
  property p_align;
    @(posedge clk) disable iff (!arst_n) syncEdge |=> count_ff == $past(expectCount) + 12'h001;
  endproperty
  a_align: assert property (p_align) else $error("counter not aligned to sync edge");
  property p_preamble;
    @(posedge clk) disable iff (!arst_n)
      (count_ff == 12'h000 && !syncEdge) |=> (linkWord_ff[9:2] == 8'hff) ##1 (linkWord_ff[9:0] == 10'h000)
      ##1 (linkWord_ff[9:0] == 10'h000) ##1 linkWord_ff[9];
  endproperty
  a_preamble: assert property (p_preamble) else $error("end code preamble wrong");
  property p_hflag;
    @(posedge clk) disable iff (!arst_n) (region == hvwf_pkg::REG_START_CODE && count_ff[1:0] == 2'b11)
      |=> linkWord_ff[6] == 1'b0 && linkWord_ff[9] && linkWord_ff[19:10] == linkWord_ff[9:0];
  endproperty
  a_hflag: assert property (p_hflag) else $error("start code H flag wrong");
  property p_range;
    @(posedge clk) disable iff (!arst_n) !wasCode_ff |-> linkWord_ff[9:2] != 8'h00 && linkWord_ff[9:2] != 8'hff
      && linkWord_ff[19:12] != 8'h00 && linkWord_ff[19:12] != 8'hff;
  endproperty
  a_range: assert property (p_range) else $error("video word in reserved range");
  property p_flags;
    @(posedge clk) disable iff (!arst_n) count_ff != lineLast |=> $stable(fld_ff) && $stable(vbl_ff);
  endproperty
  a_flags: assert property (p_flags) else $error("field flags changed mid line");
  property p_popActive;
    @(posedge clk) disable iff (!arst_n) fifoPop |-> region == hvwf_pkg::REG_ACTIVE;
  endproperty
  a_popActive: assert property (p_popActive) else $error("sample taken outside active video");
  property p_code10;
    @(posedge clk) disable iff (!arst_n) (fmt_ff != hvwf_pkg::FMT_1125 && count_ff == 12'h000 && !syncEdge)
      |=> linkWord_ff[1:0] == 2'b11;
  endproperty
  a_code10: assert property (p_code10) else $error("1250 code not ten bits");
  c_underrun: cover property (@(posedge clk) disable iff (!arst_n) underrun_ff);
  c_lock: cover property (@(posedge clk) disable iff (!arst_n) syncEdge ##1 locked_ff);
  c_rgb: cover property (@(posedge clk) disable iff (!arst_n) rgb_ff && fifoPop);
endmodule : hvwf_formatter

// *** testbench/hvwf_sink.sv ***
// Destination model: finds timing codes on the link and recovers line position and first video words
`timescale 1ns/100ps
module hvwf_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link in, one way from the single source, nothing driven back
  input wire logic [29:0] linkWord,
  // Recovered timing and video
  output logic endCodePulse,
  output logic [11:0] lineLen,
  output logic [11:0] startCodePos,
  output logic [9:0] endCode,
  output logic [9:0] startCode,
  output logic [29:0] act0,
  output logic [29:0] act1
);
  logic [7:0] h1;
  logic [7:0] h2;
  logic [7:0] h3;
  logic [11:0] pos;
  logic isCode;

  // Only the upper eight bits are matched, so 8-bit codes are found as well
  assign isCode = h3 == 8'hff && h2 == 8'h00 && h1 == 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Pos holds the line count of the word now on the link
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      h1 <= 8'h00;
      h2 <= 8'h00;
      h3 <= 8'h00;
      pos <= 12'h000;
      endCodePulse <= 1'b0;
      lineLen <= 12'h000;
      startCodePos <= 12'h000;
      endCode <= 10'h000;
      startCode <= 10'h000;
      act0 <= 30'h0;
      act1 <= 30'h0;
    end else begin
      h1 <= linkWord[9:2];
      h2 <= h1;
      h3 <= h2;
      pos <= pos + 12'h001;
      endCodePulse <= 1'b0;
      if (isCode && linkWord[6]) begin
        endCodePulse <= 1'b1;
        lineLen <= pos - 12'h003;
        endCode <= linkWord[9:0];
        pos <= 12'h004;
      end else if (isCode) begin
        startCodePos <= pos;
        startCode <= linkWord[9:0];
      end
      if (pos == startCodePos + 12'h001) begin
        act0 <= linkWord;
      end
      if (pos == startCodePos + 12'h002) begin
        act1 <= linkWord;
      end
    end
  end
endmodule : hvwf_sink

// *** testbench/testbench.sv ***
// Testbench for the HDTV video word formatter with a destination model
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] lineFormat = 2'b00;
  logic rgbMode = 1'b0;
  logic tenBit = 1'b1;
  logic analogSyncRefEdge = 1'b0;
  logic fieldSecond = 1'b0;
  logic vertBlank = 1'b0;
  logic vidValid = 1'b0;
  logic [29:0] vidData = 30'h0;
  logic vidReady;
  logic underrun_ff;
  logic locked_ff;
  logic endCodePulse;
  logic [29:0] linkWord_ff;
  logic [29:0] act0;
  logic [29:0] act1;
  logic [11:0] lineLen;
  logic [11:0] startCodePos;
  logic [9:0] endCode;
  logic [9:0] startCode;
  int mismatches = 0;
  int check_count = 0;
  int underrunCount = 0;

  always #2 clk = ~clk;
  always @(posedge clk) if (underrun_ff === 1'b1) underrunCount++;

  hvwf_formatter hvwf_formatter_inst (.clk(clk), .arst_n(arst_n), .lineFormat(lineFormat), .rgbMode(rgbMode),
    .tenBit(tenBit), .analogSyncRefEdge(analogSyncRefEdge), .fieldSecond(fieldSecond), .vertBlank(vertBlank),
    .vidValid(vidValid), .vidData(vidData), .vidReady(vidReady), .linkWord_ff(linkWord_ff),
    .underrun_ff(underrun_ff), .locked_ff(locked_ff));
  hvwf_sink hvwf_sink_inst (.clk(clk), .arst_n(arst_n), .linkWord(linkWord_ff), .endCodePulse(endCodePulse),
    .lineLen(lineLen), .startCodePos(startCodePos), .endCode(endCode), .startCode(startCode), .act0(act0),
    .act1(act1));

  ////////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task check(input logic [29:0] seen, input logic [29:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task wait_end_code;
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (endCodePulse !== 1'b1 && n < 3000);
    if (n >= 3000) mismatches++;
  endtask : wait_end_code

  function automatic logic [9:0] xyz(input logic f, input logic v, input logic h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
  endfunction : xyz

  ////////////////////////////////////////////////////////////////////////////////
  task test_formats;
    logic [11:0] len [3];
    logic [11:0] act [3];
    len = '{hvwf_pkg::LINE_LEN_1125, hvwf_pkg::LINE_LEN_1250F, hvwf_pkg::LINE_LEN_1250S};
    act = '{hvwf_pkg::PRE_SYNC_1125 + hvwf_pkg::ACT_SYNC_1125, hvwf_pkg::PRE_SYNC_1250F + hvwf_pkg::ACT_SYNC_1250F,
      hvwf_pkg::PRE_SYNC_1250S + hvwf_pkg::ACT_SYNC_1250S};
    for (int f = 0; f < 3; f++) begin
      lineFormat = f[1:0];
      fieldSecond = f[0];
      vertBlank = ~f[1];
      tenBit = ~f[1];
      wait_end_code;
      wait_end_code;
      check(lineLen, len[f]);
      check(startCodePos, act[f] - 12'h001);
      check(endCode, xyz(f[0], ~f[1], 1'b1));
      check(startCode, xyz(f[0], ~f[1], 1'b0));
    end
    tenBit = 1'b1;
    lineFormat = 2'b00;
    fieldSecond = 1'b0;
    vertBlank = 1'b0;
  endtask : test_formats

  // Second sync edge exactly one line after the first must find the counter aligned
  task test_sync;
    int n;
    wait_end_code;
    wait_end_code;
    analogSyncRefEdge = 1'b1;
    tick(8);
    analogSyncRefEdge = 1'b0;
    tick(hvwf_pkg::LINE_LEN_1125 - 8);
    analogSyncRefEdge = 1'b1;
    n = 0;
    do begin
      tick(1);
      n++;
      if (n == 8) analogSyncRefEdge = 1'b0;
    end while (endCodePulse !== 1'b1 && n < 3000);
    check(30'(n), 30'(hvwf_pkg::LINE_LEN_1125 - hvwf_pkg::PRE_SYNC_1125 + 12'h004));
    check(locked_ff, 1'b1);
  endtask : test_sync

  // Fill the FIFO until it refuses, then watch it drain over one active line
  task test_video;
    int taken;
    int u0;
    logic rdy;
    wait_end_code;
    taken = 0;
    for (int i = 0; i < 17; i++) begin
      vidData = (i == 0) ? 30'h000ffc00 : (i == 1) ? 30'h155aabff : 30'h10040100;
      vidValid = 1'b1;
      rdy = vidReady;
      tick(1);
      if (rdy === 1'b1) taken++;
    end
    vidValid = 1'b0;
    check(30'(taken), 30'(hvwf_pkg::FIFO_DEPTH));
    check(vidReady, 1'b0);
    check(linkWord_ff, {hvwf_pkg::LVL_BLACK, hvwf_pkg::LVL_ACHROM, hvwf_pkg::LVL_BLACK});
    u0 = underrunCount;
    wait_end_code;
    check(act0, {hvwf_pkg::LVL_BLACK, hvwf_pkg::VID_MAX, hvwf_pkg::VID_MIN});
    check(act1, {hvwf_pkg::LVL_BLACK, hvwf_pkg::VID_MIN, hvwf_pkg::VID_MAX});
    check(30'(underrunCount - u0), 30'(hvwf_pkg::LINE_LEN_1125 - hvwf_pkg::PRE_SYNC_1125
      - hvwf_pkg::ACT_SYNC_1125 - 12'h010));
    check(vidReady, 1'b1);
  endtask : test_video

  task test_rgb;
    rgbMode = 1'b1;
    wait_end_code;
    vidData = 30'h123ffc00;
    vidValid = 1'b1;
    tick(1);
    vidValid = 1'b0;
    wait_end_code;
    check(act0, {10'h123, hvwf_pkg::VID_MAX, hvwf_pkg::VID_MIN});
    rgbMode = 1'b0;
  endtask : test_rgb

  task test_eight;
    int n;
    tenBit = 1'b0;
    wait_end_code;
    vidData = 30'h000adeb7;
    vidValid = 1'b1;
    tick(1);
    vidValid = 1'b0;
    wait_end_code;
    check(endCode, xyz(1'b0, 1'b0, 1'b1) & hvwf_pkg::CODE_8BIT_MASK);
    check(act0, {hvwf_pkg::LVL_BLACK, 10'h2b4, 10'h2b4});
    // First start code word of this 8-bit line has its two low bits cleared
    n = 0;
    do begin
      tick(1);
      n++;
    end while (linkWord_ff[9:2] !== 8'hff && n < 3000);
    check(linkWord_ff, {3{hvwf_pkg::CODE_ONES & hvwf_pkg::CODE_8BIT_MASK}});
    tenBit = 1'b1;
  endtask : test_eight

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    arst_n = 1'b1;
    tick(2);
    test_formats;
    test_sync;
    test_video;
    test_rgb;
    test_eight;
    complete_run;
  end

  // Whole run needs about 32500 cycles
  initial begin
    #240000;
    mismatches++;
    complete_run;
  end
endmodule : testbench
